//--- shared/cmdtrn_pkg.sv
// Constants, register map and state encoding for command bus training mode 2.
// Assumes a 40 MHz register clock; every timing count is derived from it here.
`default_nettype none

package cmdtrn_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int ENTRY_DELAY_NS = 250;
    localparam int ENTRY_CYC = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_WINDOW_MAX_NS = 80;
    localparam int READ_WINDOW_CYC = (READ_WINDOW_MAX_NS / CLK_PERIOD_NS) > 0 ?
        (READ_WINDOW_MAX_NS / CLK_PERIOD_NS) : 1;
    localparam int MODE_WRITE_DELAY_NS = 50;
    localparam int MODE_WRITE_CYC = (MODE_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] ENTRY_CNT = CNT_W'(ENTRY_CYC);
    localparam logic [CNT_W-1:0] READ_WINDOW_CNT = CNT_W'(READ_WINDOW_CYC);
    localparam logic [CNT_W-1:0] MODE_WRITE_CNT = CNT_W'(MODE_WRITE_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CAREF = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TERM = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FEATURE = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;

    // Field positions and widths.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_WR_BANK_BIT = 6;
    localparam int CTRL_OP_BANK_BIT = 7;
    localparam int CAREF_W = 7;
    localparam int CAREF_MODE2_BIT = 7;
    localparam int TERM_W = 3;
    localparam int FEATURE_TERM_BIT = 7;
    localparam int CA_W = 6;
    localparam int DQ_W = 8;
    localparam int DQ_FLAG_BIT = 7;
    localparam int DQ_RANGE_BIT = 6;
    localparam int STAT_CAREF_LSB = 0;
    localparam int STAT_CA_LSB = 8;
    localparam int STAT_BANK_BIT = 16;
    localparam int STAT_TRAIN_BIT = 17;
    localparam int STAT_READY_BIT = 18;

    // Reset values.
    localparam logic [CAREF_W-1:0] CAREF_RST = 7'h1e;
    localparam logic [TERM_W-1:0] TERM_RST = 3'h0;
    localparam logic OP_BANK_RST = 1'b0;
    localparam logic DIE_TERMINATING = 1'b1;

    // Pin synchroniser layout.
    localparam int SY_W = 16;
    localparam int SY_CKE = 0;
    localparam int SY_CS = 1;
    localparam int SY_DQS = 2;
    localparam int SY_CA_LSB = 3;
    localparam int SY_DQ_LSB = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Training sequence states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ENTRY,
        ST_TRAIN,
        ST_DONE,
        ST_EXIT
    } cmdtrn_state_e;

endpackage

`default_nettype wire

//--- logic/cmdtrn_sync.sv
// Two-flop synchroniser for pins that arrive from outside the pclk domain.
// Assumes each bit is an independent level; no bus coherence is implied.
`default_nettype none

module cmdtrn_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////////
    // One pair of flops per bit; the first flop feeds only the second.
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q[g] <= 1'b0;
                    sync_out[g] <= 1'b0;
                end
                else
                begin
                    meta_q[g] <= async_in[g];
                    sync_out[g] <= meta_q[g];
                end
            end
        end
    endgenerate

endmodule // cmdtrn_sync

`default_nettype wire

//--- logic/cmdtrn_core.sv
// Command bus training mode 2 of one memory die channel, with APB mode registers.
// Assumes training pins are asynchronous to pclk and are sampled through cmdtrn_sync.
//
// Overview of operation
// - At power-up the operating set-point bank is bank zero.
// - CKE low at entry switches to the alternate bank; CKE high switches back.
// - Trained reference values are not kept; controller rewrites them after exit.
// - Strobe acts as input and its rising edges capture data lines 6 to 0.
// - Strobe termination stays on in training, valued by the active bank.
// - Lines 5 to 0 carry reference value, line 6 its range, as inputs.
// - In the read window lines 5 to 0 output latched CA; line 6 is meaningless.
// - Line 7 toggles during the read window to flag valid output.
// - After the entry delay, strobe-captured bits 6 to 0 set the new reference.
// - Values latched on the CA bus are returned asynchronously on the data lines.
// - Clearing the enable bit exits; the die is ready after the mode write delay.
// - Entry needs CKE high first; entry and exit are the same from either set-point bank.
`default_nettype none

module cmdtrn_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cmdtrn_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cke,
    input wire logic cs,
    input wire logic [cmdtrn_pkg::CA_W-1:0] ca,
    input wire logic dqs_t,
    input wire logic [cmdtrn_pkg::CAREF_W-1:0] dq_in,
    output logic [cmdtrn_pkg::DQ_W-1:0] dq_out,
    output logic [cmdtrn_pkg::DQ_W-1:0] dq_oe_n,
    output logic dqs_odt_en,
    output logic [cmdtrn_pkg::TERM_W-1:0] dqs_odt_value,
    output logic operating_setpoint_bank,
    output logic device_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection.
    logic [cmdtrn_pkg::SY_W-1:0] pins_a;
    logic [cmdtrn_pkg::SY_W-1:0] pins_s;
    logic cke_p_q;
    logic cs_p_q;
    logic dqs_p_q;

    assign pins_a = {dq_in, ca, dqs_t, cs, cke};

    cmdtrn_sync #(.W(cmdtrn_pkg::SY_W)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(pins_a),
        .sync_out(pins_s)
    );

    wire cke_s = pins_s[cmdtrn_pkg::SY_CKE];
    wire cs_s = pins_s[cmdtrn_pkg::SY_CS];
    wire dqs_s = pins_s[cmdtrn_pkg::SY_DQS];
    wire [cmdtrn_pkg::CA_W-1:0] ca_s = pins_s[cmdtrn_pkg::SY_CA_LSB +: cmdtrn_pkg::CA_W];
    wire [cmdtrn_pkg::CAREF_W-1:0] dq_s =
        pins_s[cmdtrn_pkg::SY_DQ_LSB +: cmdtrn_pkg::CAREF_W];
    wire cke_fall = cke_p_q & ~cke_s;
    wire cke_rise = ~cke_p_q & cke_s;
    wire cs_rise = ~cs_p_q & cs_s;
    wire dqs_rise = ~dqs_p_q & dqs_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cke_p_q <= 1'b0;
            cs_p_q <= 1'b0;
            dqs_p_q <= 1'b0;
        end
        else
        begin
            cke_p_q <= cke_s;
            cs_p_q <= cs_s;
            dqs_p_q <= dqs_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, registered read data.
    function automatic logic addr_mapped(input logic [cmdtrn_pkg::ADDR_W-1:0] a);
        addr_mapped = (a == cmdtrn_pkg::ADDR_CTRL) || (a == cmdtrn_pkg::ADDR_CAREF) ||
            (a == cmdtrn_pkg::ADDR_TERM) || (a == cmdtrn_pkg::ADDR_FEATURE) ||
            (a == cmdtrn_pkg::ADDR_STATUS);
    endfunction

    logic train_en_q;
    logic wr_bank_q;
    logic op_bank_q;
    logic mode2_q;
    logic alt_q;
    logic [cmdtrn_pkg::CAREF_W-1:0] caref_q [2];
    logic [cmdtrn_pkg::TERM_W-1:0] term_q [2];
    logic [cmdtrn_pkg::CAREF_W-1:0] trained_caref_q;
    logic [cmdtrn_pkg::CA_W-1:0] ca_cap_q;
    logic [cmdtrn_pkg::CNT_W-1:0] cnt_q;
    logic [cmdtrn_pkg::CNT_W-1:0] win_q;
    cmdtrn_pkg::cmdtrn_state_e state_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_w;
    logic [31:0] status_w;
    logic [cmdtrn_pkg::DQ_W-1:0] dq_out_q;
    logic [cmdtrn_pkg::DQ_W-1:0] dq_oe_n_q;
    logic odt_en_q;
    logic [cmdtrn_pkg::TERM_W-1:0] odt_value_q;
    logic bank_out_q;
    logic ready_q;

    // Compares a bus address against one register offset.
    function automatic logic is_addr(
        input logic [cmdtrn_pkg::ADDR_W-1:0] a,
        input logic [cmdtrn_pkg::ADDR_W-1:0] b
    );
        is_addr = (a == b);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register decode and selection.
    wire apb_access = psel & penable;
    wire apb_wr = apb_access & pready_q & pwrite;
    wire wr_ctrl = apb_wr & is_addr(paddr, cmdtrn_pkg::ADDR_CTRL);
    wire wr_caref = apb_wr & is_addr(paddr, cmdtrn_pkg::ADDR_CAREF);
    wire wr_term = apb_wr & is_addr(paddr, cmdtrn_pkg::ADDR_TERM);
    wire act_bank = op_bank_q ^ alt_q;
    wire training = (state_q == cmdtrn_pkg::ST_ENTRY) || (state_q == cmdtrn_pkg::ST_TRAIN);
    wire accepting = (state_q == cmdtrn_pkg::ST_TRAIN);
    wire in_window = (win_q != cmdtrn_pkg::CNT_ZERO);
    wire cnt_done = (cnt_q == cmdtrn_pkg::CNT_ZERO);
    wire [cmdtrn_pkg::CAREF_W-1:0] shown_caref =
        training ? trained_caref_q : caref_q[op_bank_q];
    wire [cmdtrn_pkg::DQ_W-1:0] dq_drive = {~dq_out_q[cmdtrn_pkg::DQ_FLAG_BIT], 1'b0, ca_cap_q};

    // Status word: reference in use, captured CA, bank and training state.
    always_comb
    begin
        status_w = '0;
        status_w[cmdtrn_pkg::STAT_CAREF_LSB +: cmdtrn_pkg::CAREF_W] = shown_caref;
        status_w[cmdtrn_pkg::STAT_CA_LSB +: cmdtrn_pkg::CA_W] = ca_cap_q;
        status_w[cmdtrn_pkg::STAT_BANK_BIT] = act_bank;
        status_w[cmdtrn_pkg::STAT_TRAIN_BIT] = training;
        status_w[cmdtrn_pkg::STAT_READY_BIT] = ready_q;
    end

    // Read data selection.
    always_comb
    begin
        rd_w = '0;
        if (is_addr(paddr, cmdtrn_pkg::ADDR_CTRL))
        begin
            rd_w[cmdtrn_pkg::CTRL_EN_BIT] = train_en_q;
            rd_w[cmdtrn_pkg::CTRL_WR_BANK_BIT] = wr_bank_q;
            rd_w[cmdtrn_pkg::CTRL_OP_BANK_BIT] = op_bank_q;
        end
        else if (is_addr(paddr, cmdtrn_pkg::ADDR_CAREF))
        begin
            rd_w[cmdtrn_pkg::CAREF_W-1:0] = caref_q[wr_bank_q];
            rd_w[cmdtrn_pkg::CAREF_MODE2_BIT] = mode2_q;
        end
        else if (is_addr(paddr, cmdtrn_pkg::ADDR_TERM))
        begin
            rd_w[cmdtrn_pkg::TERM_W-1:0] = term_q[wr_bank_q];
        end
        else if (is_addr(paddr, cmdtrn_pkg::ADDR_FEATURE))
        begin
            rd_w[cmdtrn_pkg::FEATURE_TERM_BIT] = cmdtrn_pkg::DIE_TERMINATING;
        end
        else if (is_addr(paddr, cmdtrn_pkg::ADDR_STATUS))
        begin
            rd_w = status_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: ready one cycle into the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else if (apb_access && !pready_q)
        begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_mapped(paddr);
            prdata_q <= pwrite ? '0 : rd_w;
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Control register fields and the mode 2 bit of the reference register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            train_en_q <= 1'b0;
            wr_bank_q <= 1'b0;
            op_bank_q <= cmdtrn_pkg::OP_BANK_RST;
            mode2_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                train_en_q <= pwdata[cmdtrn_pkg::CTRL_EN_BIT];
                wr_bank_q <= pwdata[cmdtrn_pkg::CTRL_WR_BANK_BIT];
                op_bank_q <= pwdata[cmdtrn_pkg::CTRL_OP_BANK_BIT];
            end
            if (wr_caref)
            begin
                mode2_q <= pwdata[cmdtrn_pkg::CAREF_MODE2_BIT];
            end
        end
    end

    // One set of reference and termination settings per set-point bank.
    genvar b;
    generate
        for (b = 0; b < 2; b++)
        begin : g_bank
            wire sel = (wr_bank_q == 1'(b));
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    caref_q[b] <= cmdtrn_pkg::CAREF_RST;
                    term_q[b] <= cmdtrn_pkg::TERM_RST;
                end
                else
                begin
                    if (wr_caref && sel)
                    begin
                        caref_q[b] <= pwdata[cmdtrn_pkg::CAREF_W-1:0];
                    end
                    if (wr_term && sel)
                    begin
                        term_q[b] <= pwdata[cmdtrn_pkg::TERM_W-1:0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Training sequence.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= cmdtrn_pkg::ST_IDLE;
            cnt_q <= cmdtrn_pkg::CNT_ZERO;
            alt_q <= 1'b0;
            ready_q <= 1'b1;
            trained_caref_q <= cmdtrn_pkg::CAREF_RST;
        end
        else
        begin
            unique case (state_q)
                cmdtrn_pkg::ST_IDLE:
                begin
                    if (train_en_q && mode2_q)
                    begin
                        state_q <= cmdtrn_pkg::ST_ARMED;
                        cnt_q <= cmdtrn_pkg::MODE_WRITE_CNT;
                        ready_q <= 1'b0;
                    end
                end
                cmdtrn_pkg::ST_ARMED:
                begin
                    if (!train_en_q)
                    begin
                        state_q <= cmdtrn_pkg::ST_IDLE;
                        ready_q <= 1'b1;
                    end
                    else if (!cnt_done)
                    begin
                        cnt_q <= cnt_q - cmdtrn_pkg::CNT_ONE;
                    end
                    else if (cke_fall)
                    begin
                        state_q <= cmdtrn_pkg::ST_ENTRY;
                        cnt_q <= cmdtrn_pkg::ENTRY_CNT;
                        alt_q <= 1'b1;
                        trained_caref_q <= caref_q[~op_bank_q];
                    end
                end
                cmdtrn_pkg::ST_ENTRY:
                begin
                    if (cke_rise)
                    begin
                        state_q <= cmdtrn_pkg::ST_DONE;
                        alt_q <= 1'b0;
                    end
                    else if (!cnt_done)
                    begin
                        cnt_q <= cnt_q - cmdtrn_pkg::CNT_ONE;
                    end
                    else
                    begin
                        state_q <= cmdtrn_pkg::ST_TRAIN;
                    end
                end
                cmdtrn_pkg::ST_TRAIN:
                begin
                    if (cke_rise)
                    begin
                        state_q <= cmdtrn_pkg::ST_DONE;
                        alt_q <= 1'b0;
                    end
                    else if (dqs_rise)
                    begin
                        trained_caref_q <= dq_s;
                    end
                end
                cmdtrn_pkg::ST_DONE:
                begin
                    if (!train_en_q)
                    begin
                        state_q <= cmdtrn_pkg::ST_EXIT;
                        cnt_q <= cmdtrn_pkg::MODE_WRITE_CNT;
                    end
                end
                cmdtrn_pkg::ST_EXIT:
                begin
                    if (!cnt_done)
                    begin
                        cnt_q <= cnt_q - cmdtrn_pkg::CNT_ONE;
                    end
                    else
                    begin
                        state_q <= cmdtrn_pkg::ST_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                default:
                begin
                    state_q <= cmdtrn_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CA capture on chip select and the asynchronous read window.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ca_cap_q <= '0;
            win_q <= cmdtrn_pkg::CNT_ZERO;
        end
        else if (accepting && cs_rise)
        begin
            ca_cap_q <= ca_s;
            win_q <= cmdtrn_pkg::READ_WINDOW_CNT;
        end
        else if (in_window)
        begin
            win_q <= win_q - cmdtrn_pkg::CNT_ONE;
        end
    end

    // Data lines drive captured CA and a toggling flag only inside the window.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dq_out_q <= '0;
            dq_oe_n_q <= '1;
        end
        else if (in_window)
        begin
            dq_out_q <= dq_drive;
            dq_oe_n_q <= '0;
        end
        else
        begin
            dq_oe_n_q <= '1;
        end
    end

    // Strobe termination, its value and the bank in use.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            odt_en_q <= 1'b0;
            odt_value_q <= cmdtrn_pkg::TERM_RST;
            bank_out_q <= cmdtrn_pkg::OP_BANK_RST;
        end
        else
        begin
            odt_en_q <= alt_q;
            odt_value_q <= term_q[act_bank];
            bank_out_q <= act_bank;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dq_out = dq_out_q;
    assign dq_oe_n = dq_oe_n_q;
    assign dqs_odt_en = odt_en_q;
    assign dqs_odt_value = odt_value_q;
    assign operating_setpoint_bank = bank_out_q;
    assign device_ready = ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the training behaviour.
    bank_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        operating_setpoint_bank == $past(act_bank))
        else $error("Operating bank output does not follow the active bank.");

    entry_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == cmdtrn_pkg::ST_ARMED && train_en_q && cnt_done && cke_fall) |=> alt_q)
        else $error("Training entry did not switch to the alternate bank.");

    exit_return_a: assert property (@(posedge pclk) disable iff (!presetn)
        (training && cke_rise) |=> !alt_q)
        else $error("Training exit did not return to the original bank.");

    odt_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        alt_q |=> dqs_odt_en)
        else $error("Strobe termination off during training.");

    caref_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        (accepting && dqs_rise && !cke_rise) |=> trained_caref_q == $past(dq_s))
        else $error("Strobe edge did not capture the reference setting.");

    ca_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
        (accepting && cs_rise) |-> ##2
        (dq_oe_n == '0 && dq_out[cmdtrn_pkg::CA_W-1:0] == $past(ca_s, 2)))
        else $error("Captured CA value not driven in the read window.");

    flag_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dq_oe_n == '0 && $past(dq_oe_n) == '0) |->
        dq_out[cmdtrn_pkg::DQ_FLAG_BIT] != $past(dq_out[cmdtrn_pkg::DQ_FLAG_BIT]))
        else $error("Valid flag did not toggle in the read window.");

    ready_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == cmdtrn_pkg::ST_EXIT && cnt_done) |=> device_ready)
        else $error("Device not ready after the exit delay.");

endmodule // cmdtrn_core

`default_nettype wire

//--- verification/cmdtrn_ctl_model.sv
// Controller-side pin model for command bus training mode 2.
// Assumes the device samples these pins through its own synchroniser.
`default_nettype none

module cmdtrn_ctl_model (
    output logic cke,
    output logic cs,
    output logic [5:0] ca,
    output logic dqs_t,
    output logic [6:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // The strobe stands still between frames; CKE starts high.
    initial
    begin
        cke = 1'b1;
        cs = 1'b0;
        ca = 6'h00;
        dqs_t = 1'b0;
        dq_in = 7'h00;
    end

    // Moves CKE at once; the bench must first let the mode write delay pass.
    task automatic set_cke(input logic v);
        cke = v;
    endtask

    // Drives range and value, one strobe period, then drives the inverted value on the lines.
    task automatic set_ref(input logic [6:0] v);
        dq_in = v;
        #100 dqs_t = 1'b1;
        #100 dqs_t = 1'b0;
        #100 dq_in = ~v;
    endtask

    // Presents a CA word and marks it with a select pulse.
    task automatic latch_ca(input logic [5:0] v);
        ca = v;
        #100 cs = 1'b1;
        #100 cs = 1'b0;
        ca = ~v;
    endtask
endmodule // cmdtrn_ctl_model

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the training block.
// Assumes the controller pin model and an APB master written here.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic err, win_prev, flag_prev;
    logic [2:0] odt_val;
    logic [5:0] ca_seen;
    int n_win, w0, exp_term;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cke, cs, dqs_t, odt_en, bank, ready;
    logic [5:0] ca;
    logic [6:0] dq_in;
    logic [7:0] dq_out, dq_oe_n;
    int fails, n_tests, cyc, n, v, exp_bank, exp_ref;

    cmdtrn_core u_cmdtrn_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cke(cke), .cs(cs), .ca(ca), .dqs_t(dqs_t), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_odt_en(odt_en), .dqs_odt_value(odt_val),
        .operating_setpoint_bank(bank), .device_ready(ready));
    cmdtrn_ctl_model u_cmdtrn_ctl_model (.cke(cke), .cs(cs), .ca(ca), .dqs_t(dqs_t),
        .dq_in(dq_in));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Watches the read window; data is taken only while the flag line is driven.
    always @(posedge pclk)
    begin
        if (dq_oe_n === 8'h00)
        begin
            ca_seen <= dq_out[5:0];
            n_win <= n_win + 1;
            if (win_prev) check("dq7", dq_out[7], !flag_prev);
        end
        win_prev <= (dq_oe_n === 8'h00);
        flag_prev <= dq_out[7];
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(95412));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_bank = 0;
        check("bank", bank, exp_bank);
        check("ready", ready, 1);
        apb(1'b0, cmdtrn_pkg::ADDR_FEATURE, 32'h0);
        check("term_die", rd[7], cmdtrn_pkg::DIE_TERMINATING);
        apb(1'b1, cmdtrn_pkg::ADDR_CTRL, 32'h40);
        exp_term = $urandom % 8;
        apb(1'b1, cmdtrn_pkg::ADDR_TERM, 32'(exp_term));
        apb(1'b1, cmdtrn_pkg::ADDR_CAREF, 32'h80);
        apb(1'b1, cmdtrn_pkg::ADDR_CTRL, 32'h41);
        apb(1'b0, 8'h3c, 32'h0);
        check("slverr", err, 1);
        check("ready", ready, 0);
        repeat (8) @(posedge pclk);
        u_cmdtrn_ctl_model.set_cke(1'b0);
        exp_bank = 1;
        for (n = 0; n < 40 && bank !== 1'b1; n++) @(posedge pclk);
        check("bank", bank, exp_bank);
        check("odt", odt_en, 1);
        check("odt_value", odt_val, exp_term);
        repeat (20) @(posedge pclk);
        repeat (4)
        begin
            exp_ref = $urandom % 128;
            u_cmdtrn_ctl_model.set_ref(7'(exp_ref));
            @(posedge pclk);
            repeat (12) @(posedge pclk);
            apb(1'b0, cmdtrn_pkg::ADDR_STATUS, 32'h0);
            check("caref", rd[6:0], exp_ref);
            v = $urandom % 64;
            w0 = n_win;
            u_cmdtrn_ctl_model.latch_ca(6'(v));
            for (n = 0; n < 20 && n_win == w0; n++) @(posedge pclk);
            @(posedge pclk);
            check("ca", ca_seen, v);
        end
        u_cmdtrn_ctl_model.set_cke(1'b1);
        @(posedge pclk);
        exp_bank = 0;
        for (n = 0; n < 40 && bank !== 1'b0; n++) @(posedge pclk);
        check("bank", bank, exp_bank);
        apb(1'b1, cmdtrn_pkg::ADDR_CTRL, 32'h40);
        for (n = 0; n < 40 && ready !== 1'b1; n++) @(posedge pclk);
        check("ready", ready, 1);
        apb(1'b0, cmdtrn_pkg::ADDR_STATUS, 32'h0);
        check("not_kept", rd[6:0], cmdtrn_pkg::CAREF_RST);
        apb(1'b1, cmdtrn_pkg::ADDR_CAREF, 32'(exp_ref));
        apb(1'b1, cmdtrn_pkg::ADDR_CTRL, 32'hc0);
        @(posedge pclk);
        check("bank", bank, 1);
        apb(1'b0, cmdtrn_pkg::ADDR_STATUS, 32'h0);
        check("trained", rd[6:0], exp_ref);
        summarize();
    end
endmodule // tb_top

`default_nettype wire
